// ---- hw/ccppwm_cmp.sv ----
`timescale 1ns/10ps
module ccppwm_cmp
  import ccppwm_pkg::*;
(
  input  wire logic [BYTE_W-1:0] i_count,
  input  wire logic [1:0]        i_fine,
  input  wire logic [DUTY_W-1:0] i_duty,
  input  wire logic [BYTE_W-1:0] i_period,
  output logic                   o_fall_hit,
  output logic                   o_period_hit,
  output logic                   o_exceed
);

  // ----------------------------------------------------------------
  // Ten-bit timebase against latched duty; 4*(period+1) steps
  // ----------------------------------------------------------------
  assign o_fall_hit   = ({i_count, i_fine} == i_duty);
  assign o_period_hit = (i_count == i_period);
  // Duty past the last step of the period never hits the fall compare
  assign o_exceed     = (i_duty[DUTY_W-1:2] > i_period);

endmodule

// ---- hw/ccppwm_pkg.sv ----
package ccppwm_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned BYTE_W   = 8;
  localparam int unsigned DUTY_W   = 10;
  localparam int unsigned ADDR_W   = 3;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned DIV_W    = 6;
  localparam int unsigned POST_W   = 4;

  // ----------------------------------------------------------------
  // Register word indices on the Avalon slave
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] IDX_UNIT_CONTROL   = 3'h0;
  localparam logic [ADDR_W-1:0] IDX_DUTY_LOW_BYTE  = 3'h1;
  localparam logic [ADDR_W-1:0] IDX_DUTY_HIGH_BYTE = 3'h2;
  localparam logic [ADDR_W-1:0] IDX_PERIOD_LIMIT   = 3'h3;
  localparam logic [ADDR_W-1:0] IDX_TIMEBASE_CTRL  = 3'h4;
  localparam logic [ADDR_W-1:0] IDX_TIMEBASE_COUNT = 3'h5;
  localparam logic [ADDR_W-1:0] IDX_PERIPH_FLAG    = 3'h6;
  localparam logic [ADDR_W-1:0] IDX_PIN_DIRECTION  = 3'h7;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned UC_MODE_LSB   = 0;
  localparam int unsigned UC_MODE_W     = 4;
  localparam int unsigned UC_DLB_LSB    = 4;
  localparam int unsigned UC_W          = 6;
  localparam int unsigned TC_PRESC_LSB  = 0;
  localparam int unsigned TC_RUN_BIT    = 2;
  localparam int unsigned TC_POST_LSB   = 3;
  localparam int unsigned TC_W          = 7;
  localparam int unsigned PF_MATCH_BIT  = 1;
  localparam int unsigned PD_PIN_BIT    = 0;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [UC_W-1:0]   UC_RESET      = 6'h00;
  localparam logic [TC_W-1:0]   TC_RESET      = 7'h00;
  localparam logic [BYTE_W-1:0] PERIOD_RESET  = 8'hff;
  localparam logic [BYTE_W-1:0] COUNT_RESET   = 8'h00;
  localparam logic [BYTE_W-1:0] DUTY_RESET    = 8'h00;
  localparam logic              PIN_DIR_RESET = 1'b1;
  localparam logic [1:0]        MODE_PWM_HI   = 2'h3;
  localparam logic [1:0]        PRESC_DIV1    = 2'h0;
  localparam logic [1:0]        PRESC_DIV4    = 2'h1;
  localparam logic [DIV_W-1:0]  DIV_LIMIT_1   = 6'h03;
  localparam logic [DIV_W-1:0]  DIV_LIMIT_4   = 6'h0f;
  localparam logic [DIV_W-1:0]  DIV_LIMIT_16  = 6'h3f;

endpackage

// ---- hw/ccppwm_prescale.sv ----
`timescale 1ns/10ps
module ccppwm_prescale
  import ccppwm_pkg::*;
(
  input  wire logic             i_core_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_run,
  input  wire logic             i_clear,
  input  wire logic [1:0]       i_sel,
  output logic                  o_tick,
  output logic [1:0]            o_fine
);

  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] limit;

  // ----------------------------------------------------------------
  // Ratio select: instruction clock times 1, 4 or 16
  // ----------------------------------------------------------------
  always_comb
  begin
    case (i_sel)
      PRESC_DIV1: limit = DIV_LIMIT_1;
      PRESC_DIV4: limit = DIV_LIMIT_4;
      default:    limit = DIV_LIMIT_16;
    endcase
  end

  // Increment enable comes straight off the core clock count
  assign o_tick = i_run && (div_reg == limit);

  // Top two bits of the position within one count step
  always_comb
  begin
    case (i_sel)
      PRESC_DIV1: o_fine = div_reg[1:0];
      PRESC_DIV4: o_fine = div_reg[3:2];
      default:    o_fine = div_reg[5:4];
    endcase
  end

  // ----------------------------------------------------------------
  // Divider counter
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst || i_clear)
      div_reg <= '0;
    else if (o_tick)
      div_reg <= '0;
    else if (i_run)
      div_reg <= div_reg + 6'h01;
  end

endmodule

// ---- hw/ccppwm_top.sv ----
`timescale 1ns/10ps
// Operation
// - Duty resolution peaks at ten bits, only with period limit at 255.
// - Duty steps equal four times (period limit plus one).
// - Duty beyond the period leaves the output pin at its present level.
// - In sleep the timebase stops and only the bus handshake and read data change.
// - In sleep a driven pin keeps its level.
// - After sleep the timebase continues from its held count.
// - Output period is derived from the core clock.
// - Any reset makes the pin an input and restores all register resets.
// - Prescaler offers divide by 1, 4 and 16.
module ccppwm_top
  import ccppwm_pkg::*;
(
  input  wire logic              i_core_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_sleep,
  input  wire logic [ADDR_W-1:0] i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [DATA_W-1:0] i_avs_writedata,
  output logic [DATA_W-1:0]      o_avs_readdata,
  output logic                   o_avs_waitrequest,
  output logic                   o_pwm_pin_out,
  output logic                   o_pwm_pin_oe_n
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [UC_W-1:0]   unit_control_reg;
  logic [BYTE_W-1:0] duty_low_byte_reg;
  logic [DUTY_W-1:0] duty_shadow_reg;
  logic [BYTE_W-1:0] period_limit_reg;
  logic [TC_W-1:0]   timebase_control_reg;
  logic [BYTE_W-1:0] timebase_count_reg;
  logic [POST_W-1:0] post_count_reg;
  logic              match_flag_reg;
  logic              pin_dir_reg;
  logic              pin_out_reg;
  logic              rise_pend_reg;
  logic              wait_reg;
  logic [DATA_W-1:0] rdata_reg;

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  logic              bus_req;
  logic              wr_go;
  logic              wr_control;
  logic              wr_duty_low;
  logic              wr_period;
  logic              wr_tctrl;
  logic              wr_count;
  logic              wr_flag;
  logic              wr_pindir;
  logic              awake;
  logic              pwm_mode;
  logic              run;
  logic              tick;
  logic [1:0]        fine;
  logic [DUTY_W-1:0] duty_full;
  logic              fall_hit;
  logic              period_hit;
  logic              exceed;
  logic              rollover;
  logic              post_done;
  logic [DATA_W-1:0] rdata_next;

  assign bus_req   = i_avs_read || i_avs_write;
  // Write lands on the edge where waitrequest is seen low
  assign wr_go     = i_avs_write && !wait_reg && awake;
  assign awake     = !i_sleep;
  assign pwm_mode  = (unit_control_reg[UC_MODE_LSB+2 +: 2] == MODE_PWM_HI);
  assign run       = timebase_control_reg[TC_RUN_BIT] && awake;
  // Duty assembled from the byte plus two control bits
  assign duty_full = {duty_low_byte_reg, unit_control_reg[UC_DLB_LSB +: 2]};
  assign rollover  = tick && period_hit && !wr_count;
  assign post_done = (post_count_reg == timebase_control_reg[TC_POST_LSB +: POST_W]);

  // Per-register write strobes
  assign wr_control  = wr_go && (i_avs_address == IDX_UNIT_CONTROL);
  assign wr_duty_low = wr_go && (i_avs_address == IDX_DUTY_LOW_BYTE);
  assign wr_period   = wr_go && (i_avs_address == IDX_PERIOD_LIMIT);
  assign wr_tctrl    = wr_go && (i_avs_address == IDX_TIMEBASE_CTRL);
  assign wr_count    = wr_go && (i_avs_address == IDX_TIMEBASE_COUNT);
  assign wr_flag     = wr_go && (i_avs_address == IDX_PERIPH_FLAG);
  assign wr_pindir   = wr_go && (i_avs_address == IDX_PIN_DIRECTION);

  // ----------------------------------------------------------------
  // Prescaler and compare
  // ----------------------------------------------------------------
  // Writing count or control restarts the divider so a step is whole
  ccppwm_prescale u_prescale (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_run      (run),
    .i_clear    (wr_count || wr_tctrl),
    .i_sel      (timebase_control_reg[TC_PRESC_LSB +: 2]),
    .o_tick     (tick),
    .o_fine     (fine)
  );

  ccppwm_cmp u_cmp (
    .i_count      (timebase_count_reg),
    .i_fine       (fine),
    .i_duty       (duty_shadow_reg),
    .i_period     (period_limit_reg),
    .o_fall_hit   (fall_hit),
    .o_period_hit (period_hit),
    .o_exceed     (exceed)
  );

  // ----------------------------------------------------------------
  // Avalon handshake: one wait cycle, then a single low cycle
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      wait_reg <= 1'b1;
    else
      wait_reg <= !(bus_req && wait_reg);
  end

  // Read mux; unmapped bits and words read as zero
  always_comb
  begin
    rdata_next = '0;
    case (i_avs_address)
      IDX_UNIT_CONTROL:   rdata_next[UC_W-1:0]   = unit_control_reg;
      IDX_DUTY_LOW_BYTE:  rdata_next[BYTE_W-1:0] = duty_low_byte_reg;
      IDX_DUTY_HIGH_BYTE: rdata_next[BYTE_W-1:0] = duty_shadow_reg[DUTY_W-1:2];
      IDX_PERIOD_LIMIT:   rdata_next[BYTE_W-1:0] = period_limit_reg;
      IDX_TIMEBASE_CTRL:  rdata_next[TC_W-1:0]   = timebase_control_reg;
      IDX_TIMEBASE_COUNT: rdata_next[BYTE_W-1:0] = timebase_count_reg;
      IDX_PERIPH_FLAG:    rdata_next[PF_MATCH_BIT] = match_flag_reg;
      IDX_PIN_DIRECTION:  rdata_next[PD_PIN_BIT] = pin_dir_reg;
      default:            rdata_next = '0;
    endcase
  end

  // Read data captured with the drop of waitrequest
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      rdata_reg <= '0;
    else if (i_avs_read && wait_reg)
      rdata_reg <= rdata_next;
  end

  // ----------------------------------------------------------------
  // Software registers, all restored by reset
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      unit_control_reg     <= UC_RESET;
      duty_low_byte_reg    <= DUTY_RESET;
      period_limit_reg     <= PERIOD_RESET;
      timebase_control_reg <= TC_RESET;
    end
    else
    begin
      if (wr_control)
        unit_control_reg <= i_avs_writedata[UC_W-1:0];
      if (wr_duty_low)
        duty_low_byte_reg <= i_avs_writedata[BYTE_W-1:0];
      if (wr_period)
        period_limit_reg <= i_avs_writedata[BYTE_W-1:0];
      if (wr_tctrl)
        timebase_control_reg <= i_avs_writedata[TC_W-1:0];
    end
  end

  // Pin starts as input; software enables the driver late
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      pin_dir_reg <= PIN_DIR_RESET;
    else if (wr_pindir)
      pin_dir_reg <= i_avs_writedata[PD_PIN_BIT];
  end

  // ----------------------------------------------------------------
  // Timebase count; frozen in sleep, no reload on wake
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      timebase_count_reg <= COUNT_RESET;
    else if (wr_count)
      timebase_count_reg <= i_avs_writedata[BYTE_W-1:0];
    else if (rollover)
      timebase_count_reg <= COUNT_RESET;
    else if (tick)
      timebase_count_reg <= timebase_count_reg + 8'h01;
  end

  // Shadow loads only at a period boundary, so a duty write never glitches
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      duty_shadow_reg <= '0;
    else if (rollover)
      duty_shadow_reg <= duty_full;
  end

  // ----------------------------------------------------------------
  // Match postscaler and sticky match flag
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst || wr_tctrl)
      post_count_reg <= '0;
    else if (rollover)
      post_count_reg <= post_done ? '0 : post_count_reg + 4'h1;
  end

  // Hardware set wins over a same-cycle software clear
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      match_flag_reg <= 1'b0;
    else if (rollover && post_done)
      match_flag_reg <= 1'b1;
    else if (wr_flag)
      match_flag_reg <= i_avs_writedata[PF_MATCH_BIT];
  end

  // Rise lags the period match by one cycle, so the pulse spans exactly duty steps
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      rise_pend_reg <= 1'b0;
    else if (awake)
      rise_pend_reg <= rollover;
  end

  // ----------------------------------------------------------------
  // Pulse output; resolution set by 4*(period+1) fine steps
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      pin_out_reg <= 1'b0;
    else if (!pwm_mode)
      pin_out_reg <= 1'b0;
    else if (!awake)
      pin_out_reg <= pin_out_reg;
    else if (rise_pend_reg)
    begin
      // Shadow already holds the new duty here
      if (duty_shadow_reg == '0)
        pin_out_reg <= 1'b0;
      else if (!exceed)
        pin_out_reg <= 1'b1;
    end
    else if (run && fall_hit && !exceed)
      pin_out_reg <= 1'b0;
  end

  assign o_avs_readdata    = rdata_reg;
  assign o_avs_waitrequest = wait_reg;
  assign o_pwm_pin_out     = pin_out_reg;
  assign o_pwm_pin_oe_n    = pin_dir_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  property p_sleep_freeze;
    i_sleep |=> $stable(timebase_count_reg) && $stable(duty_shadow_reg) && $stable(match_flag_reg)
      && $stable(rise_pend_reg);
  endproperty
  a_sleep_freeze: assert property (p_sleep_freeze) else $error("state moved in sleep");

  property p_sleep_pin;
    i_sleep && pwm_mode |=> $stable(o_pwm_pin_out);
  endproperty
  a_sleep_pin: assert property (p_sleep_pin) else $error("pin moved in sleep");

  property p_wake_resume;
    i_sleep ##1 (!i_sleep && !tick && !wr_count) |=> timebase_count_reg == $past(timebase_count_reg, 2);
  endproperty
  a_wake_resume: assert property (p_wake_resume) else $error("count lost over sleep");

  property p_rollover;
    rollover && awake |=> timebase_count_reg == COUNT_RESET && duty_shadow_reg == $past(duty_full);
  endproperty
  a_rollover: assert property (p_rollover) else $error("period match did not reload");

  property p_rise;
    pwm_mode && awake && rise_pend_reg && duty_shadow_reg != '0 && !exceed |=> o_pwm_pin_out;
  endproperty
  a_rise: assert property (p_rise) else $error("output did not rise");

  property p_fall;
    pwm_mode && awake && run && fall_hit && !exceed && !rise_pend_reg |=> !o_pwm_pin_out;
  endproperty
  a_fall: assert property (p_fall) else $error("output did not fall on duty");

  property p_exceed;
    pwm_mode && exceed |=> $stable(o_pwm_pin_out);
  endproperty
  a_exceed: assert property (p_exceed) else $error("pin toggled with duty past period");

  property p_reset;
    @(posedge i_core_clk) disable iff (1'b0)
    i_sys_rst |=> o_pwm_pin_oe_n && unit_control_reg == UC_RESET && period_limit_reg == PERIOD_RESET;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");

  property p_div1_step;
    run && timebase_control_reg[TC_PRESC_LSB +: 2] == PRESC_DIV1 && tick ##1 (run && !wr_tctrl && !wr_count)[*4]
      |-> tick;
  endproperty
  a_div1_step: assert property (p_div1_step) else $error("divide by 1 step not 4 cycles");

  property p_bus_answer;
    bus_req && o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing wrong");

  // Writes are acknowledged in sleep but must not land
  property p_sleep_write;
    i_sleep && i_avs_write |=> $stable(period_limit_reg) && $stable(unit_control_reg) && $stable(pin_dir_reg);
  endproperty
  a_sleep_write: assert property (p_sleep_write) else $error("register written in sleep");

  property p_mode_off;
    !pwm_mode |=> !o_pwm_pin_out;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("pin high outside pulse mode");

  c_rollover: cover property (rollover && pwm_mode);
  c_fall:     cover property (pwm_mode && run && fall_hit && !exceed);
  c_sleep:    cover property (i_sleep && pwm_mode && run);
  c_flag_set: cover property (rollover && post_done && wr_flag);
  c_wake:     cover property (i_sleep ##1 !i_sleep);

endmodule

// ---- tb/ccppwm_load.sv ----
`timescale 1ns/10ps
module ccppwm_load
(
  input  wire logic i_core_clk,
  input  wire logic i_pin_out,
  input  wire logic i_pin_oe_n,
  output logic      o_pin_level,
  output int        o_rises,
  output int        o_high_len,
  output int        o_period_len
);
  int   since_rise;
  int   high_cnt;
  logic prev_level;

  // Load holds a pull-down, so an undriven pin reads low, never the last value
  assign o_pin_level = i_pin_oe_n ? 1'b0 : i_pin_out;

  // Pulse timing in core cycles, measured rise to fall and rise to rise
  initial
  begin
    o_rises = 0;
    o_high_len = 0;
    o_period_len = 0;
    since_rise = 0;
    high_cnt = 0;
    prev_level = 1'b0;
  end

  always @(posedge i_core_clk)
  begin
    if (o_pin_level === 1'b1 && prev_level !== 1'b1)
    begin
      o_rises++;
      o_period_len = since_rise;
      since_rise = 1;
      high_cnt = 1;
    end
    else
    begin
      since_rise++;
      if (o_pin_level === 1'b1) high_cnt++;
    end
    if (o_pin_level === 1'b0 && prev_level === 1'b1) o_high_len = high_cnt;
    prev_level = o_pin_level;
  end
endmodule

// ---- tb/ccppwm_top_tb.sv ----
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin miscompares++; \
  $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end
module ccppwm_top_tb
  import ccppwm_pkg::*;
;
  logic              clk;
  logic              rst;
  logic              sleep;
  logic [ADDR_W-1:0] addr;
  logic              rd;
  logic              wr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic              wait_req;
  logic              pin_out;
  logic              pin_oe_n;
  logic              pin_level;
  logic              lvl;
  logic [DATA_W-1:0] rv;
  logic [DATA_W-1:0] c1;
  int                rises;
  int                high_len;
  int                period_len;
  int                miscompares;
  int                comparisons;
  int                cycles;
  int                r;
  int                r0;
  localparam logic [DATA_W-1:0] RST_EXP [8] = '{32'h00, 32'h00, 32'h00, 32'hff, 32'h00, 32'h00, 32'h00, 32'h01};

  // ----------------------------------------------------------------
  // Design, load and clock
  // ----------------------------------------------------------------
  ccppwm_top DUT (.i_core_clk(clk), .i_sys_rst(rst), .i_sleep(sleep), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req), .o_pwm_pin_out(pin_out), .o_pwm_pin_oe_n(pin_oe_n));
  ccppwm_load u_load (.i_core_clk(clk), .i_pin_out(pin_out), .i_pin_oe_n(pin_oe_n),
    .o_pin_level(pin_level), .o_rises(rises), .o_high_len(high_len), .o_period_len(period_len));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Hang guard well above the longest expected run
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  // One request held until waitrequest is sampled low; data taken at that edge
  task automatic bus_cycle(input logic [ADDR_W-1:0] a, input logic is_wr, input logic [DATA_W-1:0] d,
                           output logic [DATA_W-1:0] q);
    int n;
    @(posedge clk);
    addr <= a;
    rd <= !is_wr;
    wr <= is_wr;
    wdata <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wait_req !== 1'b0 && n < 20);
    q = rdata;
    `CHK("waitrequest", 1'b0, wait_req)
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] q;
    bus_cycle(a, 1'b1, d, q);
  endtask

  task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q);
    bus_cycle(a, 1'b0, 32'h0, q);
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  // Every register against its reset value, plus the pin released
  task automatic check_resets();
    logic [DATA_W-1:0] q;
    `CHK("pin direction", 1'b1, pin_oe_n)
    for (int i = 0; i < 8; i++)
    begin
      reg_rd(i[ADDR_W-1:0], q);
      `CHK("reset value", RST_EXP[i], q)
    end
  endtask

  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    sleep = 1'b0;
    addr = '0;
    rd = 1'b0;
    wr = 1'b0;
    wdata = '0;
    miscompares = 0;
    comparisons = 0;
    cycles = 0;
    do_reset();
    check_resets();
    $display("test reset finished");

    // Setup order: driver off, period, mode, duty, flag, prescale, run
    reg_wr(IDX_PIN_DIRECTION, 32'h01);
    reg_wr(IDX_PERIOD_LIMIT, 32'h03);
    reg_wr(IDX_UNIT_CONTROL, 32'h1c);
    reg_wr(IDX_DUTY_LOW_BYTE, 32'h01);
    reg_wr(IDX_PERIPH_FLAG, 32'h00);
    reg_wr(IDX_TIMEBASE_CTRL, 32'h00);
    reg_wr(IDX_TIMEBASE_CTRL, 32'h04);
    rv = '0;
    for (int n = 0; n < 40 && rv[PF_MATCH_BIT] !== 1'b1; n++) reg_rd(IDX_PERIPH_FLAG, rv);
    `CHK("match flag", 1'b1, rv[PF_MATCH_BIT])
    reg_wr(IDX_PIN_DIRECTION, 32'h00);
    reg_rd(IDX_DUTY_HIGH_BYTE, rv);
    `CHK("latched duty", 32'h01, rv)

    // Duty 5 of 16 steps at every prescale code, select 3 also divides by 16
    for (int sel = 0; sel < 4; sel++)
    begin
      r = (sel == 0) ? 1 : (sel == 1) ? 4 : 16;
      reg_wr(IDX_TIMEBASE_CTRL, sel);
      reg_wr(IDX_TIMEBASE_CTRL, 32'h04 | sel);
      repeat (48 * r + 8) @(posedge clk);
      `CHK("high time", 5 * r, high_len)
      `CHK("period", 16 * r, period_len)
    end
    reg_wr(IDX_DUTY_HIGH_BYTE, 32'haa);
    reg_rd(IDX_DUTY_HIGH_BYTE, rv);
    `CHK("latched duty kept", 32'h01, rv)
    $display("test prescale finished");

    // Duty above period, then zero duty: no new pulses
    reg_wr(IDX_TIMEBASE_CTRL, 32'h04);
    reg_wr(IDX_DUTY_LOW_BYTE, 32'h04);
    repeat (40) @(posedge clk);
    r0 = rises;
    lvl = pin_level;
    repeat (64) @(posedge clk);
    `CHK("rises above period", r0, rises)
    `CHK("level above period", lvl, pin_level)
    reg_wr(IDX_DUTY_LOW_BYTE, 32'h00);
    reg_wr(IDX_UNIT_CONTROL, 32'h0c);
    repeat (40) @(posedge clk);
    r0 = rises;
    repeat (64) @(posedge clk);
    `CHK("zero duty level", 1'b0, pin_level)
    `CHK("zero duty rises", r0, rises)
    $display("test exceed finished");

    // Full ten-bit resolution with period 255 and duty 1023
    reg_wr(IDX_PERIOD_LIMIT, 32'hff);
    reg_wr(IDX_DUTY_LOW_BYTE, 32'hff);
    reg_wr(IDX_UNIT_CONTROL, 32'h3c);
    repeat (3080) @(posedge clk);
    `CHK("high time 10 bit", 1023, high_len)
    `CHK("period 10 bit", 1024, period_len)
    $display("test resolution finished");

    // Sleep freezes count, pin and register writes; wake resumes the count
    sleep <= 1'b1;
    repeat (2) @(posedge clk);
    lvl = pin_level;
    r0 = rises;
    reg_rd(IDX_TIMEBASE_COUNT, c1);
    repeat (40) @(posedge clk);
    reg_rd(IDX_TIMEBASE_COUNT, rv);
    `CHK("count in sleep", c1, rv)
    reg_wr(IDX_PERIOD_LIMIT, 32'h10);
    reg_rd(IDX_PERIOD_LIMIT, rv);
    `CHK("write in sleep", 32'hff, rv)
    `CHK("pin in sleep", lvl, pin_level)
    `CHK("rises in sleep", r0, rises)
    sleep <= 1'b0;
    reg_rd(IDX_TIMEBASE_COUNT, rv);
    `CHK("count on wake", 1'b1, (rv[7:0] === c1[7:0]) || (rv[7:0] === c1[7:0] + 8'h01))
    $display("test sleep finished");

    // Leaving pulse mode drops a driven pin on the next edge
    reg_wr(IDX_UNIT_CONTROL, 32'h30);
    repeat (2) @(posedge clk);
    `CHK("pin mode off", 1'b0, pin_level)
    $display("test mode finished");

    // Reset in mid-run restores everything
    do_reset();
    check_resets();
    $display("test second reset finished");
    results();
  end
endmodule
